/* File: srtc_params.svh */
// timing, command and field constants for the single-wire clock port
`ifndef SRTC_PARAMS_SVH
`define SRTC_PARAMS_SVH
`define SRTC_CLK_MHZ 250
`define SRTC_SAMPLE_US 30
`define SRTC_RSTDET_US 300
`define SRTC_PDWAIT_US 30
`define SRTC_PDLOW_US 120
`define SRTC_INTPULSE_US 100
`define SRTC_TIMER_W 18
`define SRTC_PRESCALE 15'h7FFF
`define SRTC_CMD_RDROM 8'h33
`define SRTC_CMD_MATCH 8'h55
`define SRTC_CMD_SEARCH 8'hF0
`define SRTC_CMD_SKIP 8'hCC
`define SRTC_CMD_FETCH 8'h66
`define SRTC_CMD_LOAD 8'h99
`define SRTC_CTRL_RST 8'h00
`define SRTC_CTRL_IE 7
`define SRTC_CTRL_IS_HI 6
`define SRTC_CTRL_IS_LO 4
`define SRTC_CTRL_OSC 3
`define SRTC_BYTE_LAST 7'h07
`define SRTC_ID_LAST 7'h3F
`define SRTC_TIME_LAST 7'h1F
`define SRTC_STREAM_LAST 7'h27
`define SRTC_SEARCH_CMP 2'h2
`define SRTC_CRC_POLY 8'h8C
`endif

/* File: srtc_pkg.sv */
// shared types of the single-wire clock port
package srtc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ROMCMD, ST_RDROM, ST_MATCH, ST_SEARCH,
    ST_FNCMD, ST_FETCH, ST_WRCTL, ST_WRTIME, ST_WAIT
  } srtc_st_t;

  typedef enum logic [2:0] {SL_IDLE, SL_SLOT, SL_HIGH, SL_PWAIT, SL_PLOW} srtc_slot_st_t;

  typedef struct packed {
    srtc_st_t st;
    logic [7:0] sh;
    logic [6:0] cnt;
    logic [1:0] ph;
    logic [31:0] rtc;
    logic [31:0] rwBuf;
    logic [7:0] ctrl;
    logic [14:0] pre;
    logic loadPend;
    logic stall;
    logic [17:0] intCnt;
  } srtc_main_t;

  typedef struct packed {
    srtc_slot_st_t st;
    logic [17:0] cnt;
    logic [17:0] lowCnt;
    logic lineQ;
    logic drvZero;
    logic rstArm;
    logic pend;
    logic [1:0] pdata;
  } srtc_slot_t;
endpackage : srtc_pkg

/* File: srtc_bit_if.sv */
// valid/ready stream of received slot items between internal modules
`timescale 1ns/1ps
interface srtc_bit_if #(parameter int W = 2) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : srtc_bit_if

/* File: srtc_fifo2.sv */
// two-entry buffer between slot engine and command logic
`timescale 1ns/1ps
module srtc_fifo2 import srtc_pkg::*; #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  srtc_bit_if.snk inS,
  srtc_bit_if.src outS
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } srtc_fifo_t;

  srtc_fifo_t q, d;
  logic push, pop;

  assign inS.ready = (q.cnt != 2'h2);
  assign outS.valid = (q.cnt != 2'h0);
  assign outS.data = q.mem[q.rp];
  assign push = inS.valid && inS.ready;
  assign pop = outS.valid && outS.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = inS.data;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : srtc_fifo2

/* File: srtc_slot.sv */
// slot timing engine: edge sync, sampling, read-zero drive, reset and presence
`timescale 1ns/1ps
`include "srtc_params.svh"
module srtc_slot import srtc_pkg::*; #(
  parameter int SAMPLE_CYC = 7500,
  parameter int RSTDET_CYC = 75000,
  parameter int PDWAIT_CYC = 7500,
  parameter int PDLOW_CYC = 30000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic lineIn,
  input wire logic txZero,
  output logic lineOe,
  srtc_bit_if.src rx
);
  localparam logic [`SRTC_TIMER_W-1:0] SMP_LAST = `SRTC_TIMER_W'(SAMPLE_CYC - 1);
  localparam logic [`SRTC_TIMER_W-1:0] RST_LAST = `SRTC_TIMER_W'(RSTDET_CYC - 1);
  localparam logic [`SRTC_TIMER_W-1:0] PDW_LAST = `SRTC_TIMER_W'(PDWAIT_CYC - 1);
  localparam logic [`SRTC_TIMER_W-1:0] PDL_LAST = `SRTC_TIMER_W'(PDLOW_CYC - 1);

  srtc_slot_t q, d;

  assign rx.valid = q.pend;
  assign rx.data = q.pdata;
  assign lineOe = (q.st == SL_SLOT && q.drvZero) || (q.st == SL_PLOW);

  always_comb begin
    d = q;
    d.lineQ = lineIn;
    if (q.pend && rx.ready) begin
      d.pend = 1'b0;
    end
    // long low only arms a bus reset; the clock state is never touched
    if (lineIn) begin
      d.lowCnt = '0;
    end else if (q.lowCnt != RST_LAST) begin
      d.lowCnt = q.lowCnt + `SRTC_TIMER_W'(1);
    end else if (q.st != SL_PLOW) begin
      d.rstArm = 1'b1;
      d.st = SL_HIGH;
    end
    unique case (q.st)
      SL_IDLE: begin
        if (q.lineQ && !lineIn) begin
          d.st = SL_SLOT;
          d.cnt = '0;
          d.drvZero = txZero;
        end
      end
      SL_SLOT: begin
        d.cnt = q.cnt + `SRTC_TIMER_W'(1);
        if (q.cnt == SMP_LAST) begin
          d.pend = 1'b1;
          d.pdata = {1'b0, lineIn && !q.drvZero};
          d.st = SL_HIGH;
        end
      end
      SL_HIGH: begin
        if (lineIn && q.rstArm) begin
          d.rstArm = 1'b0;
          d.pend = 1'b1;
          d.pdata = 2'h2;
          d.st = SL_PWAIT;
          d.cnt = '0;
        end else if (lineIn) begin
          d.st = SL_IDLE;
        end
      end
      SL_PWAIT: begin
        d.cnt = q.cnt + `SRTC_TIMER_W'(1);
        if (q.cnt == PDW_LAST) begin
          d.st = SL_PLOW;
          d.cnt = '0;
        end
      end
      SL_PLOW: begin
        d.cnt = q.cnt + `SRTC_TIMER_W'(1);
        if (q.cnt == PDL_LAST) begin
          d.st = SL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.lineQ <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule : srtc_slot

/* File: srtc_port.sv */
// single-wire clock port: identity selection, clock commands and seconds counter
`timescale 1ns/1ps
`include "srtc_params.svh"
// How it works
// - fetch command snapshots the running counter when its last command bit arrives.
// - fetch returns control byte first, then counter bytes low to high.
// - reading on past the last byte repeats the same five bytes.
// - a bus reset abandons any transfer in progress.
// - first byte after load command becomes control byte immediately.
// - four counter bytes collect in the buffer, committed at next reset.
// - load with interrupts enabled pulses now or later, per time and interval.
// - oscillator off freezes the counter, making it plain four-byte storage.
// - a long low resets the protocol and commits a pending load to the counter, never touching control.
// - access runs reset, one identity command, then one clock command.
// - after reset rises, wait then drive a presence low pulse.
// - after presence take an 8-bit identity command among four.
// - identity readout sends family, serial and check byte.
// - address select compares 64 bits, proceeds only on exact match.
// - scan sends bit, complement, then reads the master's chosen bit.
// - bypass select goes straight to clock commands.
// - master starts every slot; device drives alone only for presence.
// - slots sync on the master's falling edge; delay sets sample point.
// - read zero holds the line low for the delay; one never pulls.
// - all bytes travel least significant bit first.
module srtc_port import srtc_pkg::*; #(
  parameter int SAMPLE_CYC = `SRTC_SAMPLE_US * `SRTC_CLK_MHZ,
  parameter int RSTDET_CYC = `SRTC_RSTDET_US * `SRTC_CLK_MHZ,
  parameter int PDWAIT_CYC = `SRTC_PDWAIT_US * `SRTC_CLK_MHZ,
  parameter int PDLOW_CYC = `SRTC_PDLOW_US * `SRTC_CLK_MHZ,
  parameter int INTPULSE_CYC = `SRTC_INTPULSE_US * `SRTC_CLK_MHZ,
  // arbitrary identity values, not tied to any maker
  parameter logic [7:0] FAMILY = 8'h5A,
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic lineIn,
  input wire logic xtalTick,
  output logic lineOe,
  output logic lineOut,
  output logic intOe,
  output logic intOut
);
  function automatic logic [7:0] crc56(input logic [55:0] v);
    logic [7:0] c;
    logic fb;
    c = '0;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ v[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ `SRTC_CRC_POLY;
      end
    end
    return c;
  endfunction : crc56

  // interval of 2**n seconds, n picked by the select field
  function automatic logic [4:0] ivlExp(input logic [2:0] sel);
    logic [4:0] e;
    unique case (sel)
      3'h0: e = 5'h00;
      3'h1: e = 5'h02;
      3'h2: e = 5'h05;
      3'h3: e = 5'h06;
      3'h4: e = 5'h0B;
      3'h5: e = 5'h0C;
      3'h6: e = 5'h10;
      3'h7: e = 5'h11;
    endcase
    return e;
  endfunction : ivlExp

  localparam logic [63:0] ROM_ID = {crc56({SERIAL, FAMILY}), SERIAL, FAMILY};
  localparam logic [17:0] INT_LOAD = 18'(INTPULSE_CYC);

  // identity bits go out family code first, low bit first
  function automatic logic idBit(input logic [6:0] pos);
    return ROM_ID[pos[5:0]];
  endfunction : idBit

  function automatic logic idMiss(input logic b, input logic [6:0] pos);
    return b != idBit(pos);
  endfunction : idMiss

  // fetch stream: control byte, then counter bytes, wrapping every forty bits
  function automatic logic fetchBit(input logic [7:0] c, input logic [31:0] t, input logic [6:0] pos);
    logic [39:0] s;
    s = {t, c};
    return s[pos[5:0]];
  endfunction : fetchBit

  function automatic srtc_st_t romNext(input logic [7:0] cmd);
    srtc_st_t s;
    unique case (cmd)
      `SRTC_CMD_RDROM: s = ST_RDROM;
      `SRTC_CMD_MATCH: s = ST_MATCH;
      `SRTC_CMD_SEARCH: s = ST_SEARCH;
      `SRTC_CMD_SKIP: s = ST_FNCMD;
      default: s = ST_WAIT;
    endcase
    return s;
  endfunction : romNext

  // boundary pulse once the new count has all bits below the interval bit clear
  function automatic logic irqOnTick(input logic [7:0] c, input logic [31:0] t, input logic [31:0] m);
    return c[`SRTC_CTRL_IE] && ((t & m) == 32'h0000_0000);
  endfunction : irqOnTick

  // a committed load pulses at once when the bit just below its interval bit is set or the interval is one second, else waits a boundary
  function automatic logic irqOnLoad(input logic [7:0] c, input logic [31:0] t, input logic [4:0] e);
    logic hit;
    hit = (e == 5'h00) || t[e - 5'h01];
    return c[`SRTC_CTRL_IE] && hit;
  endfunction : irqOnLoad

  srtc_main_t q, d;
  srtc_bit_if #(.W(2)) slotIf ();
  srtc_bit_if #(.W(2)) cmdIf ();
  logic txZero;
  logic take;
  logic rxBit;
  logic [7:0] shNew;
  logic [2:0] ivlSel;
  logic [31:0] ivlMask;
  logic [31:0] rtcNext;
  logic [4:0] ivlE;

  srtc_slot #(
    .SAMPLE_CYC(SAMPLE_CYC),
    .RSTDET_CYC(RSTDET_CYC),
    .PDWAIT_CYC(PDWAIT_CYC),
    .PDLOW_CYC(PDLOW_CYC)
  ) uSlot (
    .clock(clock),
    .rst_n(rst_n),
    .lineIn(lineIn),
    .txZero(txZero),
    .lineOe(lineOe),
    .rx(slotIf.src)
  );

  // a stall here backs up into the slot engine instead of losing a bit
  srtc_fifo2 #(.W(2)) uBuf (
    .clock(clock),
    .rst_n(rst_n),
    .inS(slotIf.snk),
    .outS(cmdIf.src)
  );

  assign lineOut = 1'b0;
  assign intOut = 1'b0;
  assign intOe = (q.intCnt != '0);
  // one stall cycle after a commit; the buffer holds the next item meanwhile
  assign cmdIf.ready = !q.stall;
  assign take = cmdIf.valid && cmdIf.ready;
  assign rxBit = cmdIf.data[0];
  assign shNew = {rxBit, q.sh[7:1]};
  assign ivlSel = q.ctrl[`SRTC_CTRL_IS_HI:`SRTC_CTRL_IS_LO];
  assign ivlE = ivlExp(ivlSel);
  assign ivlMask = (32'h0000_0001 << ivlE) - 32'h0000_0001;
  assign rtcNext = q.rtc + 32'h0000_0001;

  // bit to present in the coming read slot
  always_comb begin
    unique case (q.st)
      ST_RDROM: txZero = !idBit(q.cnt);
      ST_SEARCH: begin
        unique case (q.ph)
          2'h0: txZero = !idBit(q.cnt);
          2'h1: txZero = idBit(q.cnt);
          default: txZero = 1'b0;
        endcase
      end
      ST_FETCH: txZero = !fetchBit(q.ctrl, q.rwBuf, q.cnt);
      default: txZero = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.stall = 1'b0;
    if (q.intCnt != '0) begin
      d.intCnt = q.intCnt - 18'h00001;
    end
    if (xtalTick && q.ctrl[`SRTC_CTRL_OSC]) begin
      if (q.pre == `SRTC_PRESCALE) begin
        d.pre = '0;
        d.rtc = rtcNext;
        if (irqOnTick(q.ctrl, rtcNext, ivlMask)) begin
          d.intCnt = INT_LOAD;
        end
      end else begin
        d.pre = q.pre + 15'h0001;
      end
    end
    // a bus reset outranks any data bit and abandons the transfer
    if (take && cmdIf.data[1]) begin
      d.st = ST_ROMCMD;
      d.cnt = '0;
      d.ph = '0;
      if (q.loadPend) begin
        d.rtc = q.rwBuf;
        d.pre = '0;
        d.loadPend = 1'b0;
        d.stall = 1'b1;
        if (irqOnLoad(q.ctrl, q.rwBuf, ivlE)) begin
          d.intCnt = INT_LOAD;
        end
      end
    end else if (take) begin
      d.sh = shNew;
      d.cnt = q.cnt + 7'h01;
      unique case (q.st)
        ST_ROMCMD: begin
          if (q.cnt == `SRTC_BYTE_LAST) begin
            d.cnt = '0;
            d.ph = '0;
            d.st = romNext(shNew);
          end
        end
        ST_RDROM: begin
          if (q.cnt == `SRTC_ID_LAST) begin
            d.st = ST_FNCMD;
            d.cnt = '0;
          end
        end
        ST_MATCH: begin
          if (idMiss(rxBit, q.cnt)) begin
            d.st = ST_WAIT;
          end else if (q.cnt == `SRTC_ID_LAST) begin
            d.st = ST_FNCMD;
            d.cnt = '0;
          end
        end
        ST_SEARCH: begin
          d.cnt = q.cnt;
          d.ph = q.ph + 2'h1;
          if (q.ph == `SRTC_SEARCH_CMP) begin
            d.ph = '0;
            d.cnt = q.cnt + 7'h01;
            if (idMiss(rxBit, q.cnt)) begin
              d.st = ST_WAIT;
            end else if (q.cnt == `SRTC_ID_LAST) begin
              d.st = ST_FNCMD;
              d.cnt = '0;
            end
          end
        end
        ST_FNCMD: begin
          if (q.cnt == `SRTC_BYTE_LAST) begin
            d.cnt = '0;
            unique case (shNew)
              `SRTC_CMD_FETCH: begin
                d.rwBuf = q.rtc;
                d.st = ST_FETCH;
              end
              `SRTC_CMD_LOAD: d.st = ST_WRCTL;
              default: d.st = ST_WAIT;
            endcase
          end
        end
        ST_FETCH: begin
          if (q.cnt == `SRTC_STREAM_LAST) begin
            d.cnt = '0;
          end
        end
        ST_WRCTL: begin
          if (q.cnt == `SRTC_BYTE_LAST) begin
            d.ctrl = {shNew[7:3], shNew[`SRTC_CTRL_OSC], 2'b00};
            d.st = ST_WRTIME;
            d.cnt = '0;
          end
        end
        ST_WRTIME: begin
          d.rwBuf[q.cnt[4:0]] = rxBit;
          if (q.cnt == `SRTC_TIME_LAST) begin
            d.loadPend = 1'b1;
            d.st = ST_WAIT;
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= `SRTC_CTRL_RST;
    end else begin
      q <= d;
    end
  end
endmodule : srtc_port

/* File: srtc_port_props.sv */
// assertion checker for the single-wire clock port
`timescale 1ns/1ps
module srtc_port_props #(
  parameter int SAMPLE_CYC = 7500,
  parameter int RSTDET_CYC = 75000,
  parameter int PDWAIT_CYC = 7500,
  parameter int PDLOW_CYC = 30000,
  parameter int INTPULSE_CYC = 25000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic lineIn,
  input wire logic xtalTick,
  input wire logic lineOe,
  input wire logic lineOut,
  input wire logic intOe,
  input wire logic intOut
);
  logic [17:0] oeLen_q, hiLen_q, loLen_q, lastLo_q, intLen_q;
  // run lengths of each level, so long pulses need no repetition operator
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oeLen_q <= 18'h0;
      hiLen_q <= 18'h0;
      loLen_q <= 18'h0;
      lastLo_q <= 18'h0;
      intLen_q <= 18'h0;
    end else begin
      oeLen_q <= lineOe ? oeLen_q + 18'h1 : 18'h0;
      hiLen_q <= lineIn ? hiLen_q + 18'h1 : 18'h0;
      loLen_q <= lineIn ? 18'h0 : loLen_q + 18'h1;
      intLen_q <= intOe ? intLen_q + 18'h1 : 18'h0;
      if (lineIn && loLen_q != 18'h0) lastLo_q <= loLen_q;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_out_const: assert property (!lineOut && !intOut) else $error("driven level not low");
  a_rz_start: assert property ($rose(lineOe) && !$past(lineIn) |-> $past(lineIn, 2))
    else $error("read drive not one cycle after edge");
  a_oe_len: assert property ($fell(lineOe) |-> oeLen_q == SAMPLE_CYC || oeLen_q == PDLOW_CYC)
    else $error("line drive length wrong");
  a_oe_max: assert property (oeLen_q <= PDLOW_CYC) else $error("line driven too long");
  a_pd_wait: assert property ($rose(lineOe) && $past(lineIn) |->
    hiLen_q >= PDWAIT_CYC && hiLen_q <= PDWAIT_CYC + 3) else $error("presence wait wrong");
  a_pd_cause: assert property ($rose(lineOe) && $past(lineIn) |-> lastLo_q >= RSTDET_CYC)
    else $error("presence without bus reset");
  a_int_len: assert property ($fell(intOe) |-> intLen_q == INTPULSE_CYC)
    else $error("interrupt pulse length wrong");
  a_int_max: assert property (intLen_q <= INTPULSE_CYC) else $error("interrupt pulse too long");
  c_pres: cover property ($rose(lineOe) && $past(lineIn));
  c_rzero: cover property ($rose(lineOe) && !$past(lineIn));
  c_int: cover property ($rose(intOe));
endmodule : srtc_port_props
bind srtc_port srtc_port_props #(.SAMPLE_CYC(SAMPLE_CYC), .RSTDET_CYC(RSTDET_CYC), .PDWAIT_CYC(PDWAIT_CYC),
  .PDLOW_CYC(PDLOW_CYC), .INTPULSE_CYC(INTPULSE_CYC)) i_props (.clock(clock), .rst_n(rst_n),
  .lineIn(lineIn), .xtalTick(xtalTick), .lineOe(lineOe), .lineOut(lineOut), .intOe(intOe), .intOut(intOut));

/* File: srtc_master.sv */
// bus master model on the single-wire line
`timescale 1ns/1ps
module srtc_master (
  input wire logic clock,
  input wire logic lineOe,
  output logic lineIn
);
  logic low;
  initial low = 1'b0;
  // pull-up: a released line reads high
  assign lineIn = !(low || lineOe);
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic busRst(output logic pres);
    low <= 1'b1;
    cyc(120);
    low <= 1'b0;
    pres = 1'b0;
    repeat (100) begin
      @(posedge clock);
      if (!lineIn) pres = 1'b1;
    end
  endtask : busRst
  // 30-cycle slots leave recovery past the sample point
  task automatic wrBit(input logic b);
    low <= 1'b1;
    cyc(b ? 3 : 25);
    low <= 1'b0;
    cyc(b ? 27 : 5);
  endtask : wrBit
  task automatic rdBit(output logic b);
    low <= 1'b1;
    cyc(2);
    low <= 1'b0;
    cyc(6);
    b = lineIn;
    cyc(22);
  endtask : rdBit
  task automatic wrByte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) wrBit(v[i]);
  endtask : wrByte
  task automatic rdByte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rdBit(v[i]);
  endtask : rdByte
endmodule : srtc_master

/* File: test_single_wire_rtc_slave_port.sv */
// self-checking testbench for the single-wire clock port
`timescale 1ns/1ps
`include "srtc_params.svh"
module test_single_wire_rtc_slave_port;
  localparam logic [7:0] FAM = 8'h5A; // arbitrary value
  localparam logic [47:0] SER = 48'h0000_0000_0001; // arbitrary value
  logic clock, rst_n, xtalTick, lineIn, lineOe, lineOut, intOe, intOut, p, a, b;
  logic [7:0] v;
  logic [63:0] id;
  int nErrors, compares, cycles, intCnt;
  srtc_port #(.SAMPLE_CYC(20), .RSTDET_CYC(100), .PDWAIT_CYC(20), .PDLOW_CYC(40), .INTPULSE_CYC(10))
    i_dut (.clock(clock), .rst_n(rst_n), .lineIn(lineIn),
    .xtalTick(xtalTick), .lineOe(lineOe), .lineOut(lineOut), .intOe(intOe), .intOut(intOut));
  srtc_master i_master (.clock(clock), .lineOe(lineOe), .lineIn(lineIn));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (intOe === 1'b1) intCnt++;
    if (cycles == 90000) begin
      nErrors++;
      summarize();
    end
  end
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ `SRTC_CRC_POLY : c >> 1;
    return c;
  endfunction : crc8
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      nErrors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic chkF(input string s, input logic e, input logic g);
    chk(s, {7'h00, e}, {7'h00, g});
  endtask : chkF
  task automatic sel(input logic [7:0] c);
    i_master.busRst(p);
    i_master.wrByte(c);
  endtask : sel
  task automatic fetchChk(input logic [7:0] c, input logic [31:0] t);
    i_master.wrByte(`SRTC_CMD_FETCH);
    for (int k = 0; k < 10; k++) begin
      i_master.rdByte(v);
      if (k % 5 == 0) chk("ctrl", c, v);
      else chk("time", t[8 * (k % 5) - 8 +: 8], v);
    end
  endtask : fetchChk
  // n counter bytes; fewer than four never commit
  task automatic load(input logic [7:0] c, input logic [31:0] t, input int n);
    sel(`SRTC_CMD_SKIP);
    i_master.wrByte(`SRTC_CMD_LOAD);
    i_master.wrByte(c);
    for (int i = 0; i < n; i++) i_master.wrByte(t[8 * i +: 8]);
    i_master.busRst(p);
  endtask : load
  task automatic t_stop();
    load(8'h00, 32'hA1B2C3D4, 4);
    i_master.cyc(33000);
    sel(`SRTC_CMD_SKIP);
    fetchChk(8'h00, 32'hA1B2C3D4);
  endtask : t_stop
  task automatic t_part();
    load(8'h0C, 32'h11223344, 2);
    sel(`SRTC_CMD_SKIP);
    fetchChk(8'h0C, 32'hA1B2C3D4);
  endtask : t_part
  task automatic t_int();
    intCnt = 0;
    load(8'h8C, 32'h00000010, 4);
    chk("intLen", 8'h0A, intCnt[7:0]);
    sel(`SRTC_CMD_SKIP);
    fetchChk(8'h8C, 32'h00000010);
  endtask : t_int
  task automatic t_abort();
    sel(`SRTC_CMD_SKIP);
    i_master.wrByte(`SRTC_CMD_FETCH);
    i_master.rdBit(a);
    i_master.rdBit(a);
    i_master.busRst(p);
    chkF("presence", 1'b1, p);
  endtask : t_abort
  task automatic t_rom();
    sel(`SRTC_CMD_RDROM);
    for (int i = 0; i < 8; i++) begin
      i_master.rdByte(v);
      chk("rom", id[8 * i +: 8], v);
    end
    fetchChk(8'h8C, 32'h00000010);
  endtask : t_rom
  task automatic t_match();
    sel(`SRTC_CMD_MATCH);
    for (int i = 0; i < 8; i++) i_master.wrByte(id[8 * i +: 8] ^ {7'h00, i == 7});
    i_master.wrByte(`SRTC_CMD_FETCH);
    i_master.rdByte(v);
    chk("silent", 8'hFF, v);
    sel(`SRTC_CMD_MATCH);
    for (int i = 0; i < 8; i++) i_master.wrByte(id[8 * i +: 8]);
    fetchChk(8'h8C, 32'h00000010);
  endtask : t_match
  task automatic t_search();
    sel(`SRTC_CMD_SEARCH);
    for (int i = 0; i < 64; i++) begin
      i_master.rdBit(a);
      i_master.rdBit(b);
      chkF("bit", id[i], a);
      chkF("cmpl", ~id[i], b);
      i_master.wrBit(id[i]);
    end
    fetchChk(8'h8C, 32'h00000010);
    sel(`SRTC_CMD_SEARCH);
    i_master.rdBit(a);
    i_master.rdBit(b);
    i_master.wrBit(~id[0]);
    i_master.rdBit(a);
    i_master.rdBit(b);
    chkF("dropped", 1'b1, a & b);
  endtask : t_search
  task automatic summarize();
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    rst_n <= 1'b0;
    xtalTick <= 1'b1;
    nErrors = 0;
    compares = 0;
    cycles = 0;
    intCnt = 0;
    id = {crc8({SER, FAM}), SER, FAM};
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    i_master.cyc(2);
    i_master.busRst(p);
    chkF("presence", 1'b1, p);
    t_stop();
    t_part();
    t_int();
    t_abort();
    t_rom();
    t_match();
    t_search();
    summarize();
  end
endmodule : test_single_wire_rtc_slave_port
